/* File: dv/ptce_checker.sv */
// checker for the time clock unit: bus timing, pin enables, sticky flags
module ptce_checker
    import ptce_pkg::*;
#(
    parameter int FILTER = FILTER_CYCLES,
    parameter int PULSE  = PULSE_CYCLES
) (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [1:0]  timePinIn,
    input wire logic [1:0]  timePinOut,
    input wire logic [1:0]  timePinOutEnN,
    input wire logic        timeUnitEventSummary
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    logic        apbWr;
    logic        cfgWr;
    logic        rdHi;
    logic        hiSeen_r;
    logic [31:0] hiHeld_r;
    logic [5:0]  quiet_r;

    // completed transfers of interest
    assign apbWr = psel && penable && pwrite && pready;
    assign cfgWr = apbWr && paddr == OFS_CFG;
    assign rdHi  = psel && penable && !pwrite && pready && paddr == OFS_TIME_HI;

    // cycles since the last host write or pin change
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            quiet_r <= '0;
        end else if (apbWr || $changed(timePinIn)) begin
            quiet_r <= '0;
        end else if (quiet_r != 6'h3F) begin
            quiet_r <= quiet_r + 6'h01;
        end
    end

    // first high-half read after a snapshot
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hiSeen_r <= 1'b0;
            hiHeld_r <= '0;
        end else if (apbWr && paddr inside {OFS_CMD, OFS_TIME_HI, OFS_TIME_LO}) begin
            hiSeen_r <= 1'b0;
        end else if (rdHi) begin
            hiSeen_r <= 1'b1;
            hiHeld_r <= prdata;
        end
    end

    ready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    ready_single_a: assert property (pready |=> !pready)
        else $error("answer longer than one cycle");
    ready_in_access_a: assert property (pready |-> psel && penable)
        else $error("answer outside access phase");
    error_decode_a: assert property (pready |-> pslverr == (paddr > OFS_PORT_EVT || paddr[1:0] != 2'b00))
        else $error("wrong error response");
    refused_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("refused read not zero");
    oe_cause_a: assert property (!$stable(timePinOutEnN) |-> $past(cfgWr) || $past(cfgWr, 2) || $past(cfgWr, 3))
        else $error("pin enable moved without setup write");
    oe_from_cfg_a: assert property (cfgWr |-> ##2 timePinOutEnN == ~$past(pwdata[2:1], 2))
        else $error("pin enable does not follow setup write");
    flag_sticky_a: assert property ($fell(timeUnitEventSummary) |-> quiet_r < FILTER + 12)
        else $error("summary dropped without a clear");
    snap_stable_a: assert property (rdHi && hiSeen_r |-> prdata == hiHeld_r)
        else $error("snapshot changed between reads");

    cover property (rdHi && hiSeen_r);
    cover property ($rose(timePinOut[0]));
    cover property ($rose(timeUnitEventSummary));
    cover property (pready && pslverr);
    cover property ($fell(timePinOutEnN[0]));
endmodule

bind ptce_clock_event_unit ptce_checker #(.FILTER(FILTER), .PULSE(PULSE)) i_chk (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timePinIn(timePinIn), .timePinOut(timePinOut), .timePinOutEnN(timePinOutEnN),
    .timeUnitEventSummary(timeUnitEventSummary)
);

/* File: dv/ptce_clock_event_unit_tb.sv */
// testbench for the time clock unit
module ptce_clock_event_unit_tb import ptce_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  timePinIn = '0;
    logic [1:0]  timePinOut;
    logic [1:0]  timePinOutEnN;
    logic        timeUnitEventSummary;
    logic [31:0] rd, a, b, h;
    logic [63:0] p, q;
    logic        o;
    int          error_cnt = 0;
    int          compares = 0;
    int          cyc = 0;
    int          t0, tSnap;

    ptce_clock_event_unit i_dut (
        .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timePinIn(timePinIn), .timePinOut(timePinOut),
        .timePinOutEnN(timePinOutEnN), .timeUnitEventSummary(timeUnitEventSummary)
    );

    // clock and edge counter
    always #5 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;

    // ----------------------------------------
    // bus tasks and comparison
    // ----------------------------------------
    task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= ad;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        // wait for the answer; only the watchdog ends a hang
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        xfer(1'b1, ad, d);
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic rdc(input logic [7:0] ad, input logic [31:0] e);
        xfer(1'b0, ad, '0);
        chk(rd, e);
    endtask

    task automatic setTime(input logic [31:0] hi, input logic [31:0] lo);
        wr(OFS_TIME_HI, hi);
        wr(OFS_TIME_LO, lo);
    endtask

    task automatic snap();
        wr(OFS_CMD, 32'h0000_0001);
        tSnap = cyc;
        xfer(1'b0, OFS_TIME_HI, '0);
        a = rd;
        xfer(1'b0, OFS_TIME_LO, '0);
        b = rd;
    endtask

    task automatic pinPulse(input int k);
        timePinIn[k] <= 1'b1;
        repeat (8) @(posedge clock);
        timePinIn[k] <= 1'b0;
        repeat (12) @(posedge clock);
    endtask

    task automatic summarize();
        if (error_cnt == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        summarize();
    end

    // main sequence
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        rdc(OFS_ADDEND, ADDEND_RESET);
        rdc(8'h40, 32'h0000_0000);
        rdc(OFS_IRQ, 32'h0000_0100);
        wr(OFS_TIME_HI, 32'h0000_0001);
        snap();
        chk(a, 32'h0000_0000);
        wr(OFS_TIME_LO, 32'h0000_0005);
        snap();
        chk({a[3:0], b[27:0]}, 32'h1000_0005);
        // rate, rollover and wrap at both ends of the count
        for (int i = 0; i < 2; i++) begin
            h = i[0] ? 32'hFFFF_FFFF : 32'h0000_0000;
            wr(OFS_ADDEND, 32'h0000_0000);
            setTime(h, 32'hFFFF_FFF0);
            wr(OFS_ADDEND, 32'hFFFF_FFFF);
            snap();
            p = {a, b};
            t0 = tSnap;
            rdc(OFS_TIME_HI, a);
            snap();
            q = {a, b} - p;
            chk(q[31:0], 32'(tSnap - t0));
            repeat (30) @(posedge clock);
            snap();
            chk(a, h + 32'h0000_0001);
        end
        // half target write, then reload on match
        wr(OFS_ADDEND, 32'h0000_0000);
        wr(OFS_TGT_HI, 32'h0000_0001);
        wr(OFS_TGT_LO, 32'h0000_0007);
        setTime(32'h0000_0000, 32'h0000_0007);
        wr(OFS_IRQ, 32'h0100_01FF);
        wr(OFS_TGT_HI, 32'h0000_0000);
        rdc(OFS_IRQ, 32'h0100_0000);
        wr(OFS_NXT_HI, 32'h0000_0002);
        wr(OFS_NXT_LO, 32'h0000_0009);
        wr(OFS_CFG, 32'h0000_0001);
        wr(OFS_TGT_LO, 32'h0000_0007);
        rdc(OFS_IRQ, 32'h0100_0100);
        rdc(OFS_TGT_HI, 32'h0000_0002);
        rdc(OFS_TGT_LO, 32'h0000_0009);
        chk(timeUnitEventSummary, 1'b1);
        wr(OFS_IRQ, 32'h0000_0000);
        repeat (2) @(posedge clock);
        chk(timeUnitEventSummary, 1'b0);
        rdc(OFS_IRQ, 32'h0000_0100);
        // add mode, match caused by a time write
        wr(OFS_IRQ, 32'h0100_0100);
        wr(OFS_CFG, 32'h0000_0000);
        wr(OFS_NXT_HI, 32'h0000_0000);
        wr(OFS_NXT_LO, 32'h0000_0005);
        setTime(32'h0000_0002, 32'h0000_0009);
        rdc(OFS_IRQ, 32'h0100_0100);
        rdc(OFS_TGT_LO, 32'h0000_000E);
        // input pins: capture, clear only where enabled
        wr(OFS_CFG, 32'h0000_0068);
        pinPulse(0);
        rdc(OFS_IRQ, 32'h0100_0040);
        rdc(OFS_CAP8_LO, 32'h0000_0009);
        setTime(32'h0000_0002, 32'h0000_000E);
        pinPulse(1);
        rdc(OFS_IRQ, 32'h0100_01C0);
        rdc(OFS_CAP9_LO, 32'h0000_000E);
        // output pins: toggle, follow, pulse
        wr(OFS_CFG, 32'h0000_04E6);
        repeat (4) @(posedge clock);
        chk(timePinOutEnN, 2'b00);
        chk(timePinOut[1], 1'b1);
        o = timePinOut[0];
        setTime(32'h0000_0002, 32'h0000_0013);
        repeat (4) @(posedge clock);
        chk(timePinOut[0], !o);
        wr(OFS_IRQ, 32'h0100_01C0);
        repeat (4) @(posedge clock);
        chk(timePinOut[1], 1'b0);
        wr(OFS_CFG, 32'h0000_0466);
        repeat (4) @(posedge clock);
        o = timePinOut[0];
        setTime(32'h0000_0002, 32'h0000_0018);
        repeat (4) @(posedge clock);
        chk(timePinOut[0], !o);
        repeat (PULSE_CYCLES + 4) @(posedge clock);
        chk(timePinOut[0], o);
        // port flags and the masked summary
        wr(OFS_IRQ, 32'h0000_01FF);
        wr(OFS_PORT_EVT, 32'h0000_003F);
        rdc(OFS_IRQ, 32'h0000_003F);
        chk(timeUnitEventSummary, 1'b0);
        wr(OFS_IRQ, 32'h0020_0000);
        repeat (2) @(posedge clock);
        chk(timeUnitEventSummary, 1'b1);
        summarize();
    end
endmodule

/* File: logic/ptce_clock_event_unit.sv */
// time clock unit: accumulator clock, target comparator, interrupts, timing pins
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
module ptce_clock_event_unit
    import ptce_pkg::*;
#(
    parameter int FILTER = FILTER_CYCLES,
    parameter int PULSE  = PULSE_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [1:0]  timePinIn,
    output logic [1:0]       timePinOut,
    output logic [1:0]       timePinOutEnN,
    output logic             timeUnitEventSummary
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [63:0] timeCount_r, snap_r, target_r, nextTgt_r;
    logic [31:0] accum_r, addend_r, cfg_r, wrHi_r, wrLo_r;
    logic [31:0] tgtHiBuf_r, tgtLoBuf_r, nxtHiBuf_r, nxtLoBuf_r;
    logic [1:0]  timeHalf_r, tgtHalf_r, nxtHalf_r;
    logic [IRQ_FLAGS-1:0] irqSts_r, irqEn_r;
    logic [63:0] cap_r [2];
    logic [1:0]  pinSync1_r, pinSync2_r, pinLvl_r;
    logic [7:0]  filt_r [2];
    logic [7:0]  pulseCnt_r [2];
    logic [1:0]  toggle_r;

    logic        access, wrAcc, match, timeLoad;
    logic [32:0] accSum;
    logic [1:0]  pinEdge, pinActive;

    assign access = psel && penable;
    assign wrAcc  = access && pwrite;
    assign accSum = {1'b0, accum_r} + {1'b0, addend_r};
    assign match  = (timeCount_r == target_r);
    assign timeLoad = wrAcc && ((paddr == OFS_TIME_HI && timeHalf_r[0]) ||
                                (paddr == OFS_TIME_LO && timeHalf_r[1]));

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    // one wait-free access, error on unmapped offsets
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                pslverr <= (paddr > OFS_PORT_EVT) || (paddr[1:0] != 2'h0);
                case (paddr)
                    OFS_CFG:     prdata <= cfg_r;
                    OFS_TIME_HI: prdata <= snap_r[63:32];
                    OFS_TIME_LO: prdata <= snap_r[31:0];
                    OFS_ADDEND:  prdata <= addend_r;
                    OFS_TGT_HI:  prdata <= target_r[63:32];
                    OFS_TGT_LO:  prdata <= target_r[31:0];
                    OFS_NXT_HI:  prdata <= nextTgt_r[63:32];
                    OFS_NXT_LO:  prdata <= nextTgt_r[31:0];
                    OFS_IRQ:     prdata <= {7'h00, irqEn_r, 7'h00, irqSts_r};
                    OFS_SYS_IRQ: prdata <= {31'h0, timeUnitEventSummary};
                    OFS_CAP8_HI: prdata <= cap_r[0][63:32];
                    OFS_CAP8_LO: prdata <= cap_r[0][31:0];
                    OFS_CAP9_HI: prdata <= cap_r[1][63:32];
                    OFS_CAP9_LO: prdata <= cap_r[1][31:0];
                    default:     prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // configuration, addend
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfg_r    <= CFG_RESET;
            addend_r <= ADDEND_RESET;
        end else if (wrAcc && pready) begin
            if (paddr == OFS_CFG)    cfg_r    <= pwdata;
            if (paddr == OFS_ADDEND) addend_r <= pwdata; // rate trim
        end
    end

    // ------------------------------------------------------------
    // accumulator and time count
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            accum_r     <= 32'h0000_0000;
            timeCount_r <= 64'h0000_0000_0000_0000;
            wrHi_r      <= 32'h0000_0000;
            wrLo_r      <= 32'h0000_0000;
            timeHalf_r  <= 2'h0;
        end else begin
            accum_r <= accSum[31:0];
            if (timeLoad && pready) begin
                // second half completes the write
                timeCount_r <= (paddr == OFS_TIME_HI) ? {pwdata, wrLo_r} : {wrHi_r, pwdata};
                timeHalf_r  <= 2'h0;
            end else begin
                if (accSum[32])
                    timeCount_r <= timeCount_r + 64'h1;
                if (wrAcc && pready && paddr == OFS_TIME_HI) begin
                    wrHi_r <= pwdata;
                    timeHalf_r[1] <= 1'b1;
                end
                if (wrAcc && pready && paddr == OFS_TIME_LO) begin
                    wrLo_r <= pwdata;
                    timeHalf_r[0] <= 1'b1;
                end
            end
        end
    end

    // snapshot on command write
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            snap_r <= 64'h0000_0000_0000_0000;
        else if (wrAcc && pready && paddr == OFS_CMD && pwdata[CMD_SNAP_BIT])
            snap_r <= timeCount_r;
    end

    // ------------------------------------------------------------
    // target and next-target registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            target_r   <= 64'h0000_0000_0000_0000;
            nextTgt_r  <= 64'h0000_0000_0000_0000;
            tgtHiBuf_r <= 32'h0000_0000;
            tgtLoBuf_r <= 32'h0000_0000;
            nxtHiBuf_r <= 32'h0000_0000;
            nxtLoBuf_r <= 32'h0000_0000;
            tgtHalf_r  <= 2'h0;
            nxtHalf_r  <= 2'h0;
        end else begin
            // compare event updates target
            if (match) begin
                if (cfg_r[CFG_RELOAD_BIT])
                    target_r <= nextTgt_r;
                else
                    target_r <= target_r + {32'h0, nextTgt_r[31:0]};
            end
            if (wrAcc && pready) begin
                // host write after both halves wins over reload
                case (paddr)
                    OFS_TGT_HI: if (tgtHalf_r[0]) begin
                        target_r <= {pwdata, tgtLoBuf_r};
                        tgtHalf_r <= 2'h0;
                    end else begin
                        tgtHiBuf_r <= pwdata;
                        tgtHalf_r[1] <= 1'b1;
                    end
                    OFS_TGT_LO: if (tgtHalf_r[1]) begin
                        target_r <= {tgtHiBuf_r, pwdata};
                        tgtHalf_r <= 2'h0;
                    end else begin
                        tgtLoBuf_r <= pwdata;
                        tgtHalf_r[0] <= 1'b1;
                    end
                    OFS_NXT_HI: if (nxtHalf_r[0]) begin
                        nextTgt_r <= {pwdata, nxtLoBuf_r};
                        nxtHalf_r <= 2'h0;
                    end else begin
                        nxtHiBuf_r <= pwdata;
                        nxtHalf_r[1] <= 1'b1;
                    end
                    OFS_NXT_LO: if (nxtHalf_r[1]) begin
                        nextTgt_r <= {nxtHiBuf_r, pwdata};
                        nxtHalf_r <= 2'h0;
                    end else begin
                        nxtLoBuf_r <= pwdata;
                        nxtHalf_r[0] <= 1'b1;
                    end
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // timing pin inputs: sync, 40 ns filter, edge
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pinSync1_r <= 2'h0;
            pinSync2_r <= 2'h0;
        end else begin
            pinSync1_r <= timePinIn;
            pinSync2_r <= pinSync1_r;
        end
    end

    // active level after polarity
    assign pinActive = ~(pinSync2_r ^ cfg_r[CFG_POL_LSB +: 2]);

    for (genvar i = 0; i < 2; i++) begin : g_pin
        // level accepted only after it stays active past the minimum width
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                filt_r[i]   <= 8'h00;
                pinLvl_r[i] <= 1'b1;                                     // no false edge out of reset
            end else if (!pinActive[i]) begin
                filt_r[i]   <= 8'h00;
                pinLvl_r[i] <= 1'b0;
            end else if (filt_r[i] < 8'(FILTER)) begin
                filt_r[i] <= filt_r[i] + 8'h01;
            end else begin
                pinLvl_r[i] <= 1'b1;
            end
        end
        assign pinEdge[i] = pinActive[i] && !pinLvl_r[i] && filt_r[i] == 8'(FILTER)
                            && !cfg_r[CFG_OE_LSB + i];

        // capture on accepted edge
        always_ff @(posedge clock or posedge rst) begin
            if (rst)
                cap_r[i] <= 64'h0000_0000_0000_0000;
            else if (pinEdge[i])
                cap_r[i] <= timeCount_r;
        end

        // output pin: pulse, toggle or follow
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                pulseCnt_r[i]    <= 8'h00;
                toggle_r[i]      <= 1'b0;
                timePinOut[i]    <= 1'b0;
                timePinOutEnN[i] <= 1'b1;
            end else begin
                if (match)
                    pulseCnt_r[i] <= 8'(PULSE);
                else if (pulseCnt_r[i] != 8'h00)
                    pulseCnt_r[i] <= pulseCnt_r[i] - 8'h01;
                if (match)
                    toggle_r[i] <= ~toggle_r[i];
                timePinOutEnN[i] <= ~cfg_r[CFG_OE_LSB + i];
                case (cfg_r[(i == 0 ? CFG_MODE8_LSB : CFG_MODE9_LSB) +: 2])
                    MODE_PULSE:  timePinOut[i] <= (match || pulseCnt_r[i] > 8'h01)
                                                  == cfg_r[CFG_POL_LSB + i];
                    MODE_TOGGLE: timePinOut[i] <= (toggle_r[i] ^ match)
                                                  == cfg_r[CFG_POL_LSB + i];
                    MODE_FOLLOW: timePinOut[i] <= irqSts_r[IRQ_TIMER_BIT]
                                                  == cfg_r[CFG_POL_LSB + i];
                    default:     timePinOut[i] <= ~cfg_r[CFG_POL_LSB + i];
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt status, enable, summary
    // ------------------------------------------------------------
    // sticky flags, write one to clear, set beats clear
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irqSts_r <= '0;
            irqEn_r  <= '0;
        end else begin
            if (wrAcc && pready && paddr == OFS_IRQ) begin
                irqEn_r  <= pwdata[IRQ_EN_LSB +: IRQ_FLAGS];
                irqSts_r <= irqSts_r & ~pwdata[IRQ_FLAGS-1:0];
            end
            // pin clear only with its clear enable
            if ((pinEdge[0] && cfg_r[CFG_CLR_EN_LSB]) ||
                (pinEdge[1] && cfg_r[CFG_CLR_EN_LSB + 1]))
                irqSts_r[IRQ_TIMER_BIT] <= 1'b0;
            if (wrAcc && pready && paddr == OFS_PORT_EVT)
                irqSts_r[IRQ_PORT_LSB +: 6] <= irqSts_r[IRQ_PORT_LSB +: 6] | pwdata[5:0];
            if (pinEdge[0]) irqSts_r[IRQ_CAP8_BIT] <= 1'b1;
            if (pinEdge[1]) irqSts_r[IRQ_CAP9_BIT] <= 1'b1;
            if (match) irqSts_r[IRQ_TIMER_BIT] <= 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            timeUnitEventSummary <= 1'b0;
        else
            timeUnitEventSummary <= |(irqSts_r & irqEn_r);
    end
endmodule

/* File: shared/ptce_pkg.sv */
// package: register map, field positions and timing constants for the time clock unit
package ptce_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] OFS_CMD         = 8'h00; // snapshot command
    localparam logic [7:0] OFS_CFG         = 8'h04; // reload/add and pin setup
    localparam logic [7:0] OFS_TIME_HI     = 8'h08;
    localparam logic [7:0] OFS_TIME_LO     = 8'h0C;
    localparam logic [7:0] OFS_ADDEND      = 8'h10;
    localparam logic [7:0] OFS_TGT_HI      = 8'h14;
    localparam logic [7:0] OFS_TGT_LO      = 8'h18;
    localparam logic [7:0] OFS_NXT_HI      = 8'h1C;
    localparam logic [7:0] OFS_NXT_LO      = 8'h20;
    localparam logic [7:0] OFS_IRQ         = 8'h24; // status [8:0], enable [24:16]
    localparam logic [7:0] OFS_SYS_IRQ     = 8'h28; // summary bit, read only
    localparam logic [7:0] OFS_CAP8_HI     = 8'h2C;
    localparam logic [7:0] OFS_CAP8_LO     = 8'h30;
    localparam logic [7:0] OFS_CAP9_HI     = 8'h34;
    localparam logic [7:0] OFS_CAP9_LO     = 8'h38;
    localparam logic [7:0] OFS_PORT_EVT    = 8'h3C; // write-one to raise port stamp flags

    // command bit
    localparam int CMD_SNAP_BIT = 0;
    // configuration fields
    localparam int CFG_RELOAD_BIT   = 0;  // 1 reload, 0 add
    localparam int CFG_OE_LSB       = 1;  // [2:1] pin 8/9 output enable
    localparam int CFG_CLR_EN_LSB   = 3;  // [4:3] pin input clears timer flag
    localparam int CFG_POL_LSB      = 5;  // [6:5] pin polarity, 1 = active high/rising
    localparam int CFG_MODE8_LSB    = 7;  // [8:7] pin 8 output mode
    localparam int CFG_MODE9_LSB    = 9;  // [10:9] pin 9 output mode
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;

    // interrupt flag positions
    localparam int IRQ_PORT_LSB  = 0;   // [5:0] tx/rx flags of three ports
    localparam int IRQ_CAP8_BIT  = 6;
    localparam int IRQ_CAP9_BIT  = 7;
    localparam int IRQ_TIMER_BIT = 8;
    localparam int IRQ_FLAGS     = 9;
    localparam int IRQ_EN_LSB    = 16;

    // pin output modes
    localparam logic [1:0] MODE_PULSE  = 2'h0;
    localparam logic [1:0] MODE_TOGGLE = 2'h1;
    localparam logic [1:0] MODE_FOLLOW = 2'h2;

    localparam logic [31:0] ADDEND_RESET = 32'h0000_0000;

    // timing
    localparam int CLK_PERIOD_NS  = 10;
    localparam int PULSE_NS       = 100;
    localparam int PULSE_CYCLES   = PULSE_NS / CLK_PERIOD_NS;
    localparam int MIN_ACTIVE_NS  = 40;
    localparam int FILTER_CYCLES  = (MIN_ACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage
